/* File: hdl/htd_dispatch.sv */
// Notes on behaviour
// [RULE_01] five channel trigger inputs; input n launches only channel n with its waveform
// [RULE_02] broadcast input launches all five channels using channel 1's waveform
// [RULE_03] falling edge on a trigger input launches the press waveform
// [RULE_04] rising edge launches release waveform only where release is configured
// [RULE_05] pin triggers and force-sense trigger both stay active; either launches
// [RULE_06] configure sense level to 1 V for external-only triggering
// [RULE_07] per-channel release enable; cleared means rising edges produce nothing; the code gates broadcast rising edges by channel 1's release_en instead
// [RULE_08] sense reading crossing channel level counts as that channel's sense trigger
// [RULE_09] two-flop synchroniser then one-cycle pulse per edge
module htd_dispatch
  import htd_pkg::*;
(
  input  wire logic                      ref_clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      trig_in_ch1_i,
  input  wire logic                      trig_in_ch2_i,
  input  wire logic                      trig_in_ch3_i,
  input  wire logic                      trig_in_ch4_i,
  input  wire logic                      trig_in_ch5_i,
  input  wire logic                      trig_in_broadcast_i,
  input  wire htd_pkg::htd_ch_cfg_t      ch_cfg_i [htd_pkg::NUM_CH],
  input  wire logic [htd_pkg::LEVEL_W-1:0] sense_val_i [htd_pkg::NUM_CH],
  input  wire logic [htd_pkg::LAUNCH_AW-1:0] log_rd_addr_i,
  output htd_pkg::htd_launch_t           launch_o [htd_pkg::NUM_CH],
  output logic      [7:0]                log_rd_data_o,
  output logic      [htd_pkg::LAUNCH_AW-1:0] log_wr_ptr_o
);
  import htd_pkg::*;

  localparam int unsigned NPIN = NUM_CH + 1; // five channels plus broadcast

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and edge detectors
  // a pin shorter than one clock may slip between samples and be lost;
  // the trigger source must hold each level for at least one period.
  // a level still settling when sampled only delays the edge by one clock.

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] prev;
  logic [NPIN-1:0] next_sync1;
  logic [NPIN-1:0] next_sync2;
  logic [NPIN-1:0] next_prev;
  logic [NPIN-1:0] fall;
  logic [NPIN-1:0] rise;

  assign pin_raw = {trig_in_broadcast_i, trig_in_ch5_i, trig_in_ch4_i,
                    trig_in_ch3_i, trig_in_ch2_i, trig_in_ch1_i};

  // only sync2 and prev feed logic; sync1 is seen by sync2 alone
  always_comb begin
    next_sync1 = pin_raw;
    next_sync2 = sync1; // RULE_09
    next_prev  = sync2;
  end

  // idle level is high, so reset to high avoids a false press after reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sync1 <= '1;
      sync2 <= '1;
      prev  <= '1;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev  <= next_prev;
    end
  end

  assign fall = prev & ~sync2; // RULE_09
  assign rise = ~prev & sync2; // RULE_09

  // broadcast edges named apart from the channel edges for the dispatch below
  logic bc_fall;
  logic bc_rise;

  assign bc_fall = fall[NUM_CH]; // RULE_02
  assign bc_rise = rise[NUM_CH]; // RULE_02

  ////////////////////////////////////////////////////////////////////////////
  // force-sense detection
  // readings arrive on this clock already, so no synchroniser is needed here.
  // a level of all ones can still be crossed by a full-scale reading; the
  // configuring party picks a level that the actuator cannot reach.

  logic [NUM_CH-1:0] sense_above;
  logic [NUM_CH-1:0] next_sense_above;
  logic [NUM_CH-1:0] sense_hit;

  // compare reading with its channel level
  function automatic logic over_level(input logic [LEVEL_W-1:0] val,
                                      input logic [LEVEL_W-1:0] lvl);
    over_level = (val >= lvl);
  endfunction

  // a hit is the crossing, not the level, so a held press launches once
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      next_sense_above[i] = over_level(sense_val_i[i], ch_cfg_i[i].sense_level); // RULE_08
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sense_above <= CH_ZERO;
    end else begin
      sense_above <= next_sense_above;
    end
  end

  assign sense_hit = next_sense_above & ~sense_above; // RULE_08

  ////////////////////////////////////////////////////////////////////////////
  // launch dispatch
  // each channel picks one launch per cycle from five possible requests;
  // the record is registered so the playback side sees clean one-cycle starts.
  // the source channel field tells the playback side whose waveform to play.

  htd_launch_t       launch_q [NUM_CH];
  htd_launch_t       next_launch [NUM_CH];
  logic [NUM_CH-1:0] own_press;
  logic [NUM_CH-1:0] bc_press;
  logic [NUM_CH-1:0] own_release;
  logic [NUM_CH-1:0] bc_release;
  logic [NUM_CH-1:0] sense_req;
  logic              any_launch;
  logic [7:0]        log_word;

  // quiet record of a channel: no start, its own waveform source
  function automatic htd_launch_t idle_launch(input int unsigned ch);
    htd_launch_t rec;
    rec        = '0;
    rec.wave   = HTD_WAVE_PRESS;
    rec.src_ch = 3'(ch);
    return rec;
  endfunction

  // which source asks for a launch on each channel in this cycle;
  // own and broadcast requests stay apart so the priority below can order them
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      own_press[i]   = fall[i];                                    // RULE_01 RULE_03
      bc_press[i]    = bc_fall;                                    // RULE_02 RULE_03
      own_release[i] = rise[i] && ch_cfg_i[i].release_en;          // RULE_04 RULE_07
      // broadcast plays channel 1's waveform, so channel 1's release enable decides
      bc_release[i]  = bc_rise && ch_cfg_i[BCAST_SRC_CH].release_en; // RULE_02 RULE_04 RULE_07
      sense_req[i]   = sense_hit[i];                               // RULE_05
    end
  end

  // press wins over release in one cycle; pin beats broadcast; sense last.
  // a losing request is dropped, not queued: there is no buffering
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      next_launch[i] = idle_launch(i);
      if (own_press[i]) begin
        next_launch[i].start = 1'b1; // RULE_01 RULE_03
      end else if (bc_press[i]) begin
        next_launch[i].start  = 1'b1; // RULE_02 RULE_03
        next_launch[i].src_ch = 3'(BCAST_SRC_CH);
      end else if (own_release[i]) begin
        next_launch[i].start = 1'b1; // RULE_04 RULE_07
        next_launch[i].wave  = HTD_WAVE_RELEASE;
      end else if (bc_release[i]) begin
        // every channel takes channel 1 as its waveform source
        next_launch[i].start  = 1'b1; // RULE_02 RULE_04 RULE_07
        next_launch[i].wave   = HTD_WAVE_RELEASE;
        next_launch[i].src_ch = 3'(BCAST_SRC_CH);
      end else if (sense_req[i]) begin
        next_launch[i].start      = 1'b1; // RULE_05
        next_launch[i].from_sense = 1'b1;
      end
    end
  end

  // one log word per cycle with any launch; mixed kinds share the flag bits
  always_comb begin
    any_launch = 1'b0;
    log_word   = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (next_launch[i].start) begin
        any_launch              = 1'b1;
        log_word[i]             = 1'b1;
        log_word[LOG_REL_BIT]   = log_word[LOG_REL_BIT] | (next_launch[i].wave == HTD_WAVE_RELEASE);
        log_word[LOG_SENSE_BIT] = log_word[LOG_SENSE_BIT] | next_launch[i].from_sense;
      end
    end
  end

  // registered record; reset leaves every channel quiet on its own source
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        launch_q[i] <= idle_launch(i);
      end
    end else begin
      launch_q <= next_launch;
    end
  end

  assign launch_o = launch_q;

  ////////////////////////////////////////////////////////////////////////////
  // launch history: bits 4:0 channels, 6 sense, 7 release
  // the log is a debug aid only: it never holds back a launch, and when two
  // launches of different kinds share a cycle their flag bits merge.
  // after sixteen words the oldest entry is overwritten.

  htd_launch_log u_log (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .wr_i      (any_launch),
    .wr_data_i (log_word),
    .rd_addr_i (log_rd_addr_i),
    .rd_data_o (log_rd_data_o),
    .wr_ptr_o  (log_wr_ptr_o)
  );
endmodule // htd_dispatch

/* File: hdl/htd_pkg.sv */
package htd_pkg;
  // channel count and which channel's waveform the broadcast input plays
  localparam int unsigned NUM_CH       = 5;
  localparam int unsigned BCAST_SRC_CH = 0;
  localparam int unsigned SYNC_STAGES  = 2;
  localparam int unsigned LEVEL_W      = 12;
  localparam int unsigned LAUNCH_DEPTH = 16;
  localparam int unsigned LAUNCH_AW    = 4;
  // sense threshold as a configuration value (sense reading units)
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 12'hFFF;
  localparam logic [NUM_CH-1:0]  CH_ZERO   = 5'h00;
  // flag positions in a launch log word; bits 4:0 name the channels, bit 5 stays zero
  localparam int unsigned LOG_SENSE_BIT = 6;
  localparam int unsigned LOG_REL_BIT   = 7;

  // waveform kind of a launch
  typedef enum logic {
    HTD_WAVE_PRESS,
    HTD_WAVE_RELEASE
  } htd_wave_t;

  // one playback launch command per channel
  typedef struct packed {
    logic                      start;      // one-cycle launch pulse
    htd_wave_t                 wave;       // press or release waveform
    logic [2:0]                src_ch;     // channel whose configured waveform plays
    logic                      from_sense; // launched by the force-sense path
  } htd_launch_t;

  // per-channel configuration
  typedef struct packed {
    logic               release_en;
    logic [LEVEL_W-1:0] sense_level;
  } htd_ch_cfg_t;
endpackage : htd_pkg

/* File: hdl/htd_launch_log.sv */
// small log of recent launches; read data come out of a register
module htd_launch_log
  import htd_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 wr_i,
  input  wire logic [7:0]           wr_data_i,
  input  wire logic [LAUNCH_AW-1:0] rd_addr_i,
  output logic      [7:0]           rd_data_o,
  output logic      [LAUNCH_AW-1:0] wr_ptr_o
);
  logic [7:0]           mem [LAUNCH_DEPTH];
  logic [LAUNCH_AW-1:0] wr_ptr;
  logic [LAUNCH_AW-1:0] next_wr_ptr;

  // pointer advances once per logged launch and wraps
  always_comb begin
    next_wr_ptr = wr_ptr;
    if (wr_i) begin
      next_wr_ptr = wr_ptr + LAUNCH_AW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_ptr    <= '0;
      rd_data_o <= 8'h00;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_data_o <= mem[rd_addr_i];
    end
  end

  // storage has no reset; only read after being written
  always_ff @(posedge ref_clk_i) begin
    if (wr_i) begin
      mem[wr_ptr] <= wr_data_i;
    end
  end

  assign wr_ptr_o = wr_ptr;
endmodule // htd_launch_log

/* File: tb/htd_dispatch_checker.sv */
module htd_dispatch_checker (
  input wire logic                           ref_clk_i,
  input wire logic                           srst_i,
  input wire logic                           trig_in_ch1_i,
  input wire logic                           trig_in_ch2_i,
  input wire logic                           trig_in_ch3_i,
  input wire logic                           trig_in_ch4_i,
  input wire logic                           trig_in_ch5_i,
  input wire logic                           trig_in_broadcast_i,
  input wire htd_pkg::htd_ch_cfg_t           ch_cfg_i [htd_pkg::NUM_CH],
  input wire logic [htd_pkg::LEVEL_W-1:0]   sense_val_i [htd_pkg::NUM_CH],
  input wire logic [htd_pkg::LAUNCH_AW-1:0] log_rd_addr_i,
  input wire htd_pkg::htd_launch_t           launch_o [htd_pkg::NUM_CH],
  input wire logic [7:0]                     log_rd_data_o,
  input wire logic [htd_pkg::LAUNCH_AW-1:0] log_wr_ptr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import htd_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic [4:0] tr;
  logic [4:0] hit;
  logic       bc;
  // pins gathered so the channel loop can index them
  assign tr = {trig_in_ch5_i, trig_in_ch4_i, trig_in_ch3_i, trig_in_ch2_i, trig_in_ch1_i};
  assign bc = trig_in_broadcast_i;
  ////////////////////////////////////////////////////////////////////////////
  // pin edges land three cycles after sampling, sense crossings one
  for (genvar i = 0; i < 5; i++) begin : g_ch
    assign hit[i] = sense_val_i[i] >= ch_cfg_i[i].sense_level;
    AST_CH_PRESS: assert property ($fell(tr[i]) |-> ##3 launch_o[i].start && !launch_o[i].from_sense &&
      launch_o[i].wave == HTD_WAVE_PRESS && launch_o[i].src_ch == 3'(i)) else $error("press launch missing");
    AST_BC_PRESS: assert property ($fell(bc) && !$fell(tr[i]) |-> ##3 launch_o[i].start &&
      launch_o[i].wave == HTD_WAVE_PRESS && launch_o[i].src_ch == 3'h0) else $error("broadcast launch missing");
    AST_REL_ON: assert property ($rose(tr[i]) && ch_cfg_i[i].release_en && $stable(bc) |-> ##3
      launch_o[i].start && launch_o[i].wave == HTD_WAVE_RELEASE) else $error("release launch missing");
    AST_REL_OFF: assert property ($rose(tr[i]) && !ch_cfg_i[i].release_en && $stable(bc) ##2 !$rose(hit[i])
      |=> !launch_o[i].start) else $error("release launched while disabled");
    AST_REL_WAVE: assert property (launch_o[i].start && launch_o[i].wave == HTD_WAVE_RELEASE &&
      !launch_o[i].from_sense |-> ch_cfg_i[launch_o[i].src_ch].release_en) else $error("release not enabled");
    AST_SENSE: assert property ($rose(hit[i]) && $past(tr[i], 2) == $past(tr[i], 3) &&
      $past(bc, 2) == $past(bc, 3) |-> ##1 launch_o[i].start && launch_o[i].from_sense) else $error("sense launch missing");
    AST_NO_SPUR: assert property (launch_o[i].start |-> $past(tr[i], 3) != $past(tr[i], 4) ||
      $past(bc, 3) != $past(bc, 4) || ($past(hit[i]) && !$past(hit[i], 2))) else $error("launch without cause");
    AST_BC_SRC: assert property (launch_o[i].start && launch_o[i].src_ch != 3'(i) |->
      launch_o[i].src_ch == 3'h0) else $error("foreign waveform source");
  end
  cover property (launch_o[0].start && launch_o[0].wave == HTD_WAVE_RELEASE);
  cover property ($fell(bc));
  cover property (launch_o[3].start && launch_o[3].from_sense);
endmodule // htd_dispatch_checker
bind htd_dispatch htd_dispatch_checker i_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .trig_in_ch1_i(trig_in_ch1_i),
  .trig_in_ch2_i(trig_in_ch2_i), .trig_in_ch3_i(trig_in_ch3_i), .trig_in_ch4_i(trig_in_ch4_i),
  .trig_in_ch5_i(trig_in_ch5_i), .trig_in_broadcast_i(trig_in_broadcast_i), .ch_cfg_i(ch_cfg_i),
  .sense_val_i(sense_val_i), .log_rd_addr_i(log_rd_addr_i), .launch_o(launch_o), .log_rd_data_o(log_rd_data_o),
  .log_wr_ptr_o(log_wr_ptr_o));

/* File: tb/htd_trig_src.sv */
// external trigger source; slow mode mimics a photo coupler lag of one cycle
module htd_trig_src (
  input  wire logic       ref_clk_i,
  input  wire logic       slow_i,
  input  wire logic [5:0] lvl_i,
  output logic      [5:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] lag = 6'h3F;
  initial pin_o = 6'h3F; // idle high
  // pins change just after the edge, like the bench's own drive
  always @(posedge ref_clk_i) begin
    lag   <= #2 lvl_i;
    pin_o <= #2 slow_i ? lag : lvl_i;
  end
endmodule // htd_trig_src

/* File: tb/test_haptic_trigger_dispatch.sv */
module test_haptic_trigger_dispatch;
  timeunit 1ns;
  timeprecision 1ps;
  import htd_pkg::*;
  logic ref_clk_i, srst_i, slow;
  logic [5:0] lvl, pins;
  htd_ch_cfg_t cfg [NUM_CH];
  logic [LEVEL_W-1:0] sv [NUM_CH];
  logic [LAUNCH_AW-1:0] addr, wptr, exp_ptr;
  logic [7:0] rdat, exp_word;
  htd_launch_t lo [NUM_CH], last [NUM_CH];
  int cnt [NUM_CH];
  int n_errors, total_checks, p;
  logic [31:0] rs;
  htd_dispatch i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .trig_in_ch1_i(pins[0]), .trig_in_ch2_i(pins[1]),
    .trig_in_ch3_i(pins[2]), .trig_in_ch4_i(pins[3]), .trig_in_ch5_i(pins[4]), .trig_in_broadcast_i(pins[5]),
    .ch_cfg_i(cfg), .sense_val_i(sv), .log_rd_addr_i(addr), .launch_o(lo), .log_rd_data_o(rdat),
    .log_wr_ptr_o(wptr));
  htd_trig_src i_src (.ref_clk_i(ref_clk_i), .slow_i(slow), .lvl_i(lvl), .pin_o(pins));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic htd_launch_t exp_l(input int src, input logic rise);
    return '{1'b1, rise ? HTD_WAVE_RELEASE : HTD_WAVE_PRESS, 3'(src), 1'b0};
  endfunction
  // expected log word: channel mask, sense flag in bit 6, release flag in bit 7
  function automatic logic [7:0] exp_log(input int pn, input logic rel, input logic sns);
    return {rel, sns, 1'b0, (pn == 5) ? 5'h1F : 5'(1 << pn)};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expct);
    total_checks++;
    if (seen !== expct) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, expct, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // launch monitor; start stands one cycle so every edge is sampled
  always @(posedge ref_clk_i) for (int i = 0; i < 5; i++) if (lo[i].start === 1'b1) begin
    cnt[i]++;
    last[i] = lo[i];
  end
  // one pin edge, then every channel is judged once the pipeline has drained
  task automatic pin_op(input int pn, input logic v);
    int src;
    logic en;
    src = (pn == 5) ? 0 : pn;
    en = !v || cfg[src].release_en;
    @(posedge ref_clk_i) #2 lvl[pn] = v;
    for (int i = 0; i < 5; i++) cnt[i] = 0;
    if (en) begin
      exp_ptr++;
      exp_word = exp_log(pn, v, 1'b0);
    end
    addr = exp_ptr - 4'h1;
    repeat (12) @(posedge ref_clk_i);
    #2;
    check("log pointer", 8'(wptr), 8'(exp_ptr));
    check("log word", rdat, exp_word);
    for (int i = 0; i < 5; i++) begin
      check("launch count", 8'(cnt[i]), {7'h00, en && (pn == 5 || pn == i)});
      if (en && (pn == 5 || pn == i)) check("launch word", {2'h0, last[i]}, {2'h0, exp_l(src, v)});
    end
    $display("pin %0d to %b done", pn, v);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    complete_run();
  end
  initial begin
    {srst_i, lvl, slow, addr, n_errors, total_checks, rs} = {1'b1, 6'h3F, 1'b0, 4'h0, 64'h0, 32'h536AB0FF};
    for (int i = 0; i < 5; i++) {cfg[i], sv[i], cnt[i]} = {1'b0, LEVEL_RST, 12'h000, 32'h0};
    exp_ptr = 4'h0;
    exp_word = 8'h00;
    repeat (5) @(posedge ref_clk_i);
    #2 srst_i = 1'b0;
    // broadcast release refused because channel 1 has release off
    pin_op(5, 1'b0);
    pin_op(5, 1'b1);
    for (int t = 0; t < 60; t++) begin
      rs = xs(rs);
      {slow, addr} = {rs[8], rs[7:4]};
      for (int i = 0; i < 5; i++) cfg[i].release_en = rs[9 + i];
      p = rs[31:16] % 6;
      pin_op(p, !lvl[p]);
    end
    // sense launches while pins may still be held low elsewhere
    for (int c = 0; c < 5; c++) begin
      rs = xs(rs);
      cfg[c].sense_level = 12'h800;
      @(posedge ref_clk_i) #2 sv[c] = 12'h800 | rs[10:0];
      cnt[c] = 0;
      exp_ptr++;
      exp_word = exp_log(c, 1'b0, 1'b1);
      addr = exp_ptr - 4'h1;
      repeat (4) @(posedge ref_clk_i);
      #2 check("sense count", 8'(cnt[c]), 8'h01);
      check("sense flag", {7'h00, last[c].from_sense}, 8'h01);
      check("sense log pointer", 8'(wptr), 8'(exp_ptr));
      check("sense log word", rdat, exp_word);
      sv[c] = 12'h000;
      $display("sense %0d done", c);
    end
    complete_run();
  end
endmodule // test_haptic_trigger_dispatch
